//--- logic/pie_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.svh"

module pie_ctrl #(
    parameter int N_SRC = 32,
    parameter int N_FAST = 8,
    parameter int N_CHAN = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [N_SRC-1:0] i_src_req,
    input wire logic [N_FAST-1:0] i_fast_pin,
    input wire logic i_swt_req,
    input wire pie_pkg::pie_trap_t i_swt_num,
    output logic o_cpu_req,
    output pie_pkg::pie_trap_t o_cpu_trap,
    output pie_pkg::pie_vec_t o_cpu_vector,
    output pie_pkg::pie_lvl_t o_cpu_level,
    input wire logic i_cpu_ack,
    input wire logic i_cpu_reti,
    output logic o_xfer_valid,
    output logic [15:0] o_xfer_src,
    output logic [15:0] o_xfer_dst,
    output logic o_xfer_byte,
    output logic o_irq
);
    import pie_pkg::*;

    // Channel field is three bits and node index five bits
    if (N_CHAN != 8 || N_SRC < 1 || N_SRC > 32 || N_FAST < 1 || N_FAST > N_SRC || N_FAST > 16) begin : g_bad
        $error("pie_ctrl: unsupported parameter set");
    end

    // Trap number of a node in table order
    function automatic pie_trap_t trap_of(input logic [4:0] idx);
        if (idx < 5'd16) begin
            trap_of = `PIE_TRAP_LO_BASE + 7'(idx);
        end else if (idx < `PIE_NODE_LATE) begin
            trap_of = `PIE_TRAP_HI_BASE + 7'(idx - 5'd16);
        end else if (idx == `PIE_NODE_LATE) begin
            trap_of = `PIE_TRAP_LATE;
        end else begin
            trap_of = `PIE_TRAP_TOP_BASE + 7'(idx - 5'd30);
        end
    endfunction

    // Highest set bit of a level mask, zero when empty
    function automatic pie_lvl_t top_bit(input logic [15:0] m);
        top_bit = 4'h0;
        for (int b = 0; b < 16; b++) begin
            if (m[b]) begin
                top_bit = 4'(b);
            end
        end
    endfunction

    // Byte lane mask from Avalon byte enables
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Node state: request flags and {en, route, channel, level}
    logic [N_SRC-1:0] node_req_r;
    logic [N_SRC-1:0] node_req_nxt;
    logic [`PIE_ND_CFG_HI:0] node_cfg_r [N_SRC];
    // Channel control: {incdst, byte, cont, count}
    logic [`PIE_CH_CTL_HI:0] chan_ctl_r [N_CHAN];
    // Edge select, status, mask, accepted level stack
    logic [2*N_FAST-1:0] edge_cfg_r;
    logic [`PIE_ST_W-1:0] stat_r;
    logic [`PIE_ST_W-1:0] mask_r;
    logic [15:0] act_r;
    // Software trap latched until the CPU takes it
    logic swt_pend_r;
    pie_trap_t swt_num_r;
    // Engine registers
    pie_state_t st_r;
    logic [4:0] win_r;
    pie_lvl_t win_lvl_r;
    logic is_swt_r;
    logic [15:0] src_r;
    // Bus pipeline
    logic [1:0] bus_cnt_r;
    logic [31:0] rd_data_r;

    // Fast pin synchronisers; a change counts once stages two and three agree
    logic [N_FAST-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
    logic [N_FAST-1:0] pin_new, pin_rise, pin_fall, edge_hit;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_lvl_r <= '0;
        end else begin
            pin_s1_r <= i_fast_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_lvl_r <= pin_new;
        end
    end
    assign pin_new = (pin_s2_r ~^ pin_s3_r) & pin_s3_r | ~(pin_s2_r ~^ pin_s3_r) & pin_lvl_r;
    assign pin_rise = pin_new & ~pin_lvl_r;
    assign pin_fall = ~pin_new & pin_lvl_r;

    // Per-pin edge select, then merge with the peripheral requests
    logic [N_SRC-1:0] src_evt;
    for (genvar k = 0; k < N_SRC; k++) begin : g_evt
        if (k < N_FAST) begin : g_pin
            assign edge_hit[k] = (edge_cfg_r[2*k] & pin_rise[k]) | (edge_cfg_r[2*k+1] & pin_fall[k]);
            assign src_evt[k] = i_src_req[k] | edge_hit[k];
        end else begin : g_plain
            assign src_evt[k] = i_src_req[k];
        end
    end

    // Arbitration: highest enabled level wins, ties to lowest node
    logic best_found;
    logic [4:0] best_idx;
    pie_lvl_t best_lvl;
    always_comb begin
        best_found = 1'b0;
        best_idx = 5'h00;
        best_lvl = 4'h0;
        for (int i = 0; i < N_SRC; i++) begin
            if (node_req_r[i] && node_cfg_r[i][`PIE_ND_EN] &&
                (!best_found || node_cfg_r[i][`PIE_ND_LVL_HI:`PIE_ND_LVL_LO] > best_lvl)) begin
                best_found = 1'b1;
                best_idx = 5'(i);
                best_lvl = node_cfg_r[i][`PIE_ND_LVL_HI:`PIE_ND_LVL_LO];
            end
        end
    end

    // Current service level and acceptance test
    pie_lvl_t cur_lvl;
    logic take_ok;
    assign cur_lvl = top_bit(act_r);
    assign take_ok = best_found && (best_lvl > cur_lvl);

    // Winner decode
    logic [2:0] win_ch;
    logic win_route;
    logic [`PIE_CH_CTL_HI:0] win_ctl;
    logic win_cont;
    logic cnt_zero;
    logic last_xfer;
    assign win_ch = node_cfg_r[win_r][`PIE_ND_CH_HI:`PIE_ND_CH_LO];
    assign win_route = node_cfg_r[win_r][`PIE_ND_ROUTE];
    assign win_ctl = chan_ctl_r[win_ch];
    assign win_cont = win_ctl[`PIE_CH_CONT];
    assign cnt_zero = (win_ctl[`PIE_CH_CNT_HI:0] == 8'h00);
    assign last_xfer = !win_cont && (win_ctl[`PIE_CH_CNT_HI:0] == 8'h01);

    // Bus decode
    logic bus_req, bus_go, bus_done, bus_wr;
    logic hit_node, hit_chan;
    logic [4:0] nidx;
    logic [2:0] cidx;
    logic [1:0] creg;
    logic [31:0] wd, rd_mux;
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_go = (st_r == ST_IDLE) || (st_r == ST_PICK) || (st_r == ST_IRQ);
    assign bus_done = bus_req && (bus_cnt_r == `PIE_BUS_LAST) && bus_go;
    assign bus_wr = bus_done && i_avs_write;
    assign nidx = i_avs_address[6:2];
    assign cidx = i_avs_address[6:4];
    assign creg = i_avs_address[3:2];
    assign hit_node = (i_avs_address < `PIE_OFS_NODE_END) && (32'(nidx) < N_SRC);
    assign hit_chan = (i_avs_address >= `PIE_OFS_CHAN_BASE) && (i_avs_address < `PIE_OFS_CHAN_END);
    // Old value was fetched one cycle earlier, so partial writes merge
    assign wd = (rd_data_r & ~lane_mask(i_avs_byteenable)) | (i_avs_writedata & lane_mask(i_avs_byteenable));
    assign o_avs_waitrequest = bus_req && !bus_done;
    assign o_avs_readdata = rd_data_r;

    // Pointer memory ports; the engine owns them outside bus_go
    logic mem_we;
    logic [3:0] mem_waddr, mem_raddr;
    logic [15:0] mem_wdata, mem_rdata, ptr_old;
    logic win_incdst;
    assign win_incdst = win_ctl[`PIE_CH_INCDST];
    assign ptr_old = win_incdst ? mem_rdata : src_r;
    assign mem_we = (st_r == ST_MOVE) || (bus_wr && hit_chan && (creg == `PIE_CHR_SRC || creg == `PIE_CHR_DST));
    assign mem_waddr = (st_r == ST_MOVE) ? {win_ch, win_incdst} : {cidx, creg == `PIE_CHR_DST};
    // Bump by one for bytes and two for words
    assign mem_wdata = (st_r == ST_MOVE) ? ptr_old + (win_ctl[`PIE_CH_BYTE] ? 16'h0001 : 16'h0002) : wd[15:0];
    assign mem_raddr = (st_r == ST_RD_SRC) ? {win_ch, 1'b0} :
                       (st_r == ST_RD_DST) ? {win_ch, 1'b1} : {cidx, creg == `PIE_CHR_DST};

    pie_ptr_mem #(.W(16), .DEPTH(16), .AW(4)) u_ptr (
        .i_clk_sys(i_clk_sys),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    // Read mux; unmapped addresses read zero
    assign rd_mux = hit_node ? {22'h0, node_req_r[nidx], node_cfg_r[nidx]} :
                    (hit_chan && creg == `PIE_CHR_CTL) ? {21'h0, chan_ctl_r[cidx]} :
                    (hit_chan && creg != 2'h3) ? {16'h0, mem_rdata} :
                    (i_avs_address == `PIE_OFS_EDGE) ? 32'(edge_cfg_r) :
                    (i_avs_address == `PIE_OFS_STAT) ? 32'(stat_r) :
                    (i_avs_address == `PIE_OFS_MASK) ? 32'(mask_r) :
                    (i_avs_address == `PIE_OFS_CUR) ? {12'h0, act_r, cur_lvl} : 32'h0000_0000;

    // Request flag update: events win over any clear
    logic eng_clr, hw_ack, swt_ack, lost_evt;
    logic [N_SRC-1:0] bus_set, bus_clr, win_hot;
    assign win_hot = N_SRC'(1) << win_r;
    assign hw_ack = (st_r == ST_IRQ) && i_cpu_ack && !is_swt_r;
    assign swt_ack = (st_r == ST_IRQ) && i_cpu_ack && is_swt_r;
    // At the last count the flag stays up for the vectored interrupt
    assign eng_clr = hw_ack || ((st_r == ST_MOVE) && !last_xfer);
    assign bus_set = (bus_wr && hit_node && wd[`PIE_ND_REQ]) ? N_SRC'(1) << nidx : '0;
    assign bus_clr = (bus_wr && hit_node && !wd[`PIE_ND_REQ]) ? N_SRC'(1) << nidx : '0;
    assign node_req_nxt = (node_req_r & ~(eng_clr ? win_hot : '0) & ~bus_clr) | bus_set | src_evt;
    assign lost_evt = |(src_evt & node_req_r);

    // Node registers
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            node_req_r <= '0;
            for (int i = 0; i < N_SRC; i++) node_cfg_r[i] <= '0;
        end else begin
            node_req_r <= node_req_nxt;
            if (bus_wr && hit_node) node_cfg_r[nidx] <= wd[`PIE_ND_CFG_HI:0];
        end
    end

    // Channel counters: bus load, or decrement on each move outside continuous mode
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            for (int c = 0; c < N_CHAN; c++) chan_ctl_r[c] <= '0;
        end else if (bus_wr && hit_chan && creg == `PIE_CHR_CTL) begin
            chan_ctl_r[cidx] <= wd[`PIE_CH_CTL_HI:0];
        end else if (st_r == ST_MOVE && !win_cont) begin
            chan_ctl_r[win_ch][`PIE_CH_CNT_HI:0] <= win_ctl[`PIE_CH_CNT_HI:0] - 8'h01;
        end
    end

    // Control, sticky status (set beats write-one-clear) and level stack
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            edge_cfg_r <= '0;
            mask_r <= '0;
            stat_r <= '0;
            act_r <= 16'h0000;
        end else begin
            if (bus_wr && i_avs_address == `PIE_OFS_EDGE) edge_cfg_r <= wd[2*N_FAST-1:0];
            if (bus_wr && i_avs_address == `PIE_OFS_MASK) mask_r <= wd[`PIE_ST_W-1:0];
            stat_r <= (stat_r & ~((bus_wr && i_avs_address == `PIE_OFS_STAT) ? wd[`PIE_ST_W-1:0] : 2'h0))
                      | {lost_evt, (st_r == ST_MOVE) && last_xfer};
            act_r <= (act_r & ~(i_cpu_reti ? 16'h0001 << cur_lvl : 16'h0000))
                     | (hw_ack ? 16'h0001 << win_lvl_r : 16'h0000);
        end
    end
    assign o_irq = |(stat_r & mask_r);

    // Software trap latch; a new trap while one is pending is dropped
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            swt_pend_r <= 1'b0;
            swt_num_r <= 7'h00;
        end else if (i_swt_req && !swt_pend_r) begin
            swt_pend_r <= 1'b1;
            swt_num_r <= i_swt_num;
        end else if (swt_ack) begin
            swt_pend_r <= 1'b0;
        end
    end

    // Bus pipeline: fetch old value, then complete when the engine allows
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            bus_cnt_r <= 2'h0;
            rd_data_r <= 32'h0000_0000;
        end else if (bus_done || !bus_req) begin
            bus_cnt_r <= 2'h0;
        end else if (bus_cnt_r == 2'h0 && bus_go) begin
            bus_cnt_r <= 2'h1;
        end else if (bus_cnt_r == 2'h1) begin
            bus_cnt_r <= `PIE_BUS_LAST;
            rd_data_r <= rd_mux;
        end
    end

    // Service engine
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st_r <= ST_IDLE;
            win_r <= 5'h00;
            win_lvl_r <= 4'h0;
            is_swt_r <= 1'b0;
            src_r <= 16'h0000;
            o_cpu_trap <= 7'h00;
            o_xfer_valid <= 1'b0;
            o_xfer_src <= 16'h0000;
            o_xfer_dst <= 16'h0000;
            o_xfer_byte <= 1'b0;
        end else begin
            o_xfer_valid <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    // The trap instruction runs synchronously, so it goes first
                    if (swt_pend_r) begin
                        is_swt_r <= 1'b1;
                        win_lvl_r <= cur_lvl;
                        st_r <= ST_PICK;
                    end else if (take_ok) begin
                        is_swt_r <= 1'b0;
                        win_r <= best_idx;
                        win_lvl_r <= best_lvl;
                        st_r <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    o_cpu_trap <= is_swt_r ? swt_num_r : trap_of(win_r);
                    if (!is_swt_r && win_route && (win_cont || !cnt_zero)) begin
                        st_r <= ST_RD_SRC;
                    end else begin
                        st_r <= ST_IRQ;
                    end
                end
                ST_RD_SRC: st_r <= ST_RD_DST;
                ST_RD_DST: begin
                    src_r <= mem_rdata;
                    st_r <= ST_MOVE;
                end
                ST_MOVE: begin
                    // One stolen bus cycle, no vector fetch
                    o_xfer_valid <= 1'b1;
                    o_xfer_src <= src_r;
                    o_xfer_dst <= mem_rdata;
                    o_xfer_byte <= win_ctl[`PIE_CH_BYTE];
                    st_r <= ST_IDLE;
                end
                ST_IRQ: begin
                    // Re-arbitrate if withdrawn or outranked before acceptance
                    if (i_cpu_ack) begin
                        st_r <= ST_IDLE;
                    end else if (!is_swt_r && (!node_req_r[win_r] || (take_ok && best_lvl > win_lvl_r))) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // CPU side: vector is the trap number times four
    assign o_cpu_req = (st_r == ST_IRQ);
    assign o_cpu_vector = {7'h00, o_cpu_trap, 2'b00};
    assign o_cpu_level = win_lvl_r;

    // Checks
    localparam int RESP_CYC = `PIE_RESP_MAX_NS / `PIE_CLK_NS;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_move_path;
        (st_r == ST_PICK) ##1 (st_r == ST_RD_SRC) ##1 (st_r == ST_RD_DST) ##1 (st_r == ST_MOVE);
    endsequence

    resp_bound_a: assert property ((st_r == ST_IDLE && take_ok && !swt_pend_r)
        |-> ##[1:12] (o_cpu_req || o_xfer_valid)) else $error("service not started in time");
    steal_one_a: assert property (s_move_path |=> o_xfer_valid ##1 !o_xfer_valid)
        else $error("transfer cycle not single");
    xfer_novec_a: assert property (o_xfer_valid |-> !o_cpu_req) else $error("transfer raised a vector");
    cnt_dec_a: assert property ((st_r == ST_MOVE && !win_cont)
        |=> win_ctl[`PIE_CH_CNT_HI:0] == 8'($past(win_ctl[`PIE_CH_CNT_HI:0]) - 8'h01)) else $error("count not decremented");
    cnt_hold_a: assert property ((st_r == ST_MOVE && win_cont) |=> $stable(win_ctl))
        else $error("continuous count changed");
    zero_irq_a: assert property ((st_r == ST_PICK && !is_swt_r && win_route && !win_cont && cnt_zero)
        |=> o_cpu_req && o_cpu_trap == trap_of(win_r)) else $error("zero count gave no interrupt");
    vec_map_a: assert property ((o_cpu_req && !is_swt_r)
        |-> o_cpu_vector == {7'h00, trap_of(win_r), 2'b00}) else $error("vector mismatch");
    preempt_only_a: assert property (hw_ack |-> win_lvl_r > $past(cur_lvl, 1) || win_lvl_r > cur_lvl)
        else $error("accepted without higher level");
    pin_edge_a: assert property (edge_hit[0] |=> node_req_r[0]) else $error("edge lost");
    swt_trap_a: assert property ((st_r == ST_IDLE && swt_pend_r) |=> ##1 (o_cpu_req && o_cpu_trap == swt_num_r))
        else $error("software trap number wrong");
    resp_cyc_a: assert property ((st_r == ST_IDLE && swt_pend_r) |-> ##[1:RESP_CYC] o_cpu_req)
        else $error("trap service not started in time");
endmodule // pie_ctrl

`default_nettype wire

//--- inc/pie_defines.svh
`ifndef PIE_DEFINES_SVH
`define PIE_DEFINES_SVH

// Byte offsets on the register bus (12-bit byte address)
`define PIE_OFS_NODE_END 12'h080
`define PIE_OFS_CHAN_BASE 12'h100
`define PIE_OFS_CHAN_END 12'h180
`define PIE_OFS_EDGE 12'h180
`define PIE_OFS_STAT 12'h184
`define PIE_OFS_MASK 12'h188
`define PIE_OFS_CUR 12'h18C

// Node control word fields
`define PIE_ND_LVL_HI 3
`define PIE_ND_LVL_LO 0
`define PIE_ND_CH_HI 6
`define PIE_ND_CH_LO 4
`define PIE_ND_ROUTE 7
`define PIE_ND_EN 8
`define PIE_ND_CFG_HI 8
`define PIE_ND_REQ 9

// Channel control word fields
`define PIE_CH_CNT_HI 7
`define PIE_CH_CONT 8
`define PIE_CH_BYTE 9
`define PIE_CH_INCDST 10
`define PIE_CH_CTL_HI 10

// Channel register selector inside a channel's block
`define PIE_CHR_CTL 2'h0
`define PIE_CHR_SRC 2'h1
`define PIE_CHR_DST 2'h2

// Status bits of the bus interrupt
`define PIE_ST_ZERO 0
`define PIE_ST_LOST 1
`define PIE_ST_W 2

// Trap number bases of the node table
`define PIE_TRAP_LO_BASE 7'h10
`define PIE_TRAP_HI_BASE 7'h30
`define PIE_TRAP_TOP_BASE 7'h45
// The last capture node leaves the linear run and sits on its own trap
`define PIE_NODE_LATE 5'd29
`define PIE_TRAP_LATE 7'h44

// Response bound, ns, and bus pipeline depth
`define PIE_RESP_MAX_NS 120
`define PIE_CLK_NS 10
`define PIE_BUS_LAST 2'h2

`endif

//--- inc/pie_pkg.sv
package pie_pkg;
    // Trap number, priority level and vector types
    typedef logic [6:0] pie_trap_t;
    typedef logic [3:0] pie_lvl_t;
    typedef logic [15:0] pie_vec_t;
    // Edge select of a fast pin: bit 0 rising, bit 1 falling
    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } pie_edge_t;
    // Service engine; Gray steps along both paths except the return to ST_IDLE
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PICK = 3'h1,
        ST_RD_SRC = 3'h3,
        ST_RD_DST = 3'h2,
        ST_MOVE = 3'h6,
        ST_IRQ = 3'h5
    } pie_state_t;
endpackage

//--- logic/pie_ptr_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Pointer store: one write port, one read port, registered read data
module pie_ptr_mem #(
    parameter int W = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    // Storage array; no reset, software loads the pointers
    logic [W-1:0] mem_r [DEPTH];

    // Address width must cover the depth exactly
    if (DEPTH != (1 << AW) || W < 1) begin : g_bad_size
        $error("pie_ptr_mem: DEPTH must equal 2**AW");
    end

    // Write and registered read
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_r[i_raddr];
    end
endmodule // pie_ptr_mem

`default_nettype wire

//--- test/pie_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// CPU side: takes an offered request when idle, ends the service DLY cycles later
module pie_cpu_model #(
    parameter int DLY = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_cpu_req,
    input wire pie_pkg::pie_trap_t i_cpu_trap,
    input wire pie_pkg::pie_vec_t i_cpu_vector,
    output logic o_cpu_ack,
    output logic o_cpu_reti,
    output pie_pkg::pie_trap_t o_trap,
    output pie_pkg::pie_vec_t o_vec,
    output int o_n
);
    import pie_pkg::*;
    int wt; // Cycles left in the running service
    // A service in progress ignores new offers, so even higher levels must wait
    always_ff @(posedge i_clk_sys) begin
        o_cpu_ack <= 1'b0;
        o_cpu_reti <= 1'b0;
        if (i_sys_rst) begin
            wt <= 0;
            o_n <= 0;
        end else if (wt != 0) begin
            wt <= wt - 1;
            o_cpu_reti <= (wt == 1);
        end else if (i_cpu_req) begin
            o_cpu_ack <= 1'b1;
            o_trap <= i_cpu_trap;
            o_vec <= i_cpu_vector;
            o_n <= o_n + 1;
            wt <= DLY;
        end
    end
endmodule // pie_cpu_model
`default_nettype wire

//--- test/pie_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pie_ctrl_tb_top;
    import pie_pkg::*;
    logic clk, rst, rd, wr, wq, wq_n, swt, xv, xb, cb, ack, reti, creq, irq;
    logic [11:0] adr;
    logic [31:0] wd, rdata, rq, q_n, sreq;
    logic [7:0] pin;
    logic [15:0] xs, xd, cs, cd;
    pie_trap_t snum, ctrap, m_trap;
    pie_vec_t cvec, m_vec;
    pie_lvl_t clvl;
    int m_n, na, nx, xn, mismatches, n_tests;
    int nd[6] = '{0, 15, 16, 28, 29, 30}; // Nodes spread over the table
    pie_trap_t tr[6] = '{7'h10, 7'h1F, 7'h30, 7'h3C, 7'h44, 7'h45};
    pie_ctrl u_pie_ctrl (.i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wq), .i_src_req(sreq), .i_fast_pin(pin), .i_swt_req(swt), .i_swt_num(snum),
        .o_cpu_req(creq), .o_cpu_trap(ctrap), .o_cpu_vector(cvec), .o_cpu_level(clvl), .i_cpu_ack(ack),
        .i_cpu_reti(reti), .o_xfer_valid(xv), .o_xfer_src(xs), .o_xfer_dst(xd), .o_xfer_byte(xb),
        .o_irq(irq));
    pie_cpu_model u_pie_cpu_model (.i_clk_sys(clk), .i_sys_rst(rst), .i_cpu_req(creq), .i_cpu_trap(ctrap),
        .i_cpu_vector(cvec), .o_cpu_ack(ack), .o_cpu_reti(reti), .o_trap(m_trap), .o_vec(m_vec), .o_n(m_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Settled copies, so the edge test never races the design's updates
    always @(negedge clk) begin
        wq_n = wq;
        q_n = rdata;
    end
    // Catch each one-cycle transfer
    always @(posedge clk) begin
        if (xv === 1'b1) begin
            cs <= xs;
            cd <= xd;
            cb <= xb;
            xn <= xn + 1;
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wq_n !== 1'b0 && k < 20);
        if (k >= 20) begin
            mismatches++;
            $display("mismatch at %0t: bus timeout", $time);
            report_and_stop();
        end
        rq = q_n;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic pulse(input logic [31:0] m);
        @(posedge clk);
        sreq <= m;
        @(posedge clk);
        sreq <= '0;
    endtask
    // Bounded wait for a counter to reach its expected value
    task automatic wcnt(ref int c, input int e, input int b);
        int k;
        k = 0;
        while (c != e && k < b) begin
            @(posedge clk);
            k++;
        end
        if (c != e) begin
            mismatches++;
            $display("mismatch at %0t: no answer", $time);
            report_and_stop();
        end
    endtask
    task automatic acc(input int b, input pie_trap_t t);
        na++;
        wcnt(m_n, na, b);
        chk(32'(m_trap), 32'(t));
        chk(32'(m_vec), 32'({t, 2'b00}));
    endtask
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = '0; wd = '0; sreq = '0; pin = '0; swt = 1'b0; snum = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(1, 12'h000, 32'h0000_0105);
        bus(0, 12'h000, 0);
        chk(rq, 32'h0000_0105);
        bus(0, 12'h190, 0);
        chk(rq, 32'h0000_0000);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            bus(1, 12'(nd[i] * 4), 32'h100 | 32'(i + 1));
            pulse(32'h1 << nd[i]);
            acc(12, tr[i]);
        end
        $display("test vectors done");
        // Both pending together: level 9 first, level 2 after the return
        bus(1, 12'h004, 32'h0000_0102);
        bus(1, 12'h008, 32'h0000_0109);
        pulse(32'h0000_0006);
        acc(40, 7'h12);
        chk(32'(clvl), 32'h0000_0009);
        acc(40, 7'h11);
        bus(1, 12'h00C, 32'h0000_0304);
        acc(40, 7'h13);
        @(posedge clk);
        swt <= 1'b1;
        snum <= 7'h2A;
        @(posedge clk);
        swt <= 1'b0;
        acc(40, 7'h2A);
        // Rise, then fall, then both, toggling the pin each time
        for (int m = 1; m < 4; m++) begin
            bus(1, 12'h180, 32'(m));
            @(posedge clk);
            pin[0] <= ~pin[0];
            acc(40, 7'h10);
        end
        $display("test sources done");
        // Top channel, byte moves, destination increments, count 2
        bus(1, 12'h170, 32'h0000_0602);
        bus(1, 12'h174, 32'h0000_1000);
        bus(1, 12'h178, 32'h0000_2000);
        bus(1, 12'h010, 32'h0000_01F3);
        for (int t = 0; t < 2; t++) begin
            pulse(32'h0000_0010);
            nx++;
            wcnt(xn, nx, 20);
            chk({cs, cd}, {16'h1000, 16'h2000 + 16'(t)});
            chk(32'(cb), 1);
            chk(32'(m_n), 32'(na));
            bus(0, 12'h170, 0);
            chk(32'(rq[7:0]), 32'(1 - t));
        end
        acc(40, 7'h14);
        bus(0, 12'h184, 0);
        chk(rq & 32'h1, 32'h1);
        chk(32'(irq), 0);
        bus(1, 12'h188, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(32'(irq), 1);
        bus(1, 12'h184, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(32'(irq), 0);
        bus(1, 12'h170, 32'h0000_0705);
        pulse(32'h0000_0010);
        nx++;
        wcnt(xn, nx, 20);
        bus(0, 12'h170, 0);
        chk(rq, 32'h0000_0705);
        $display("test transfers done");
        report_and_stop();
    end
endmodule // pie_ctrl_tb_top
`default_nettype wire
